//--- inc/sarc_pkg.sv
// Package: register map, fields, reset values and timing for the SAR control logic
package sarc_pkg;
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int RW = 12;

  localparam logic [AW-1:0] OFS_SC1  = 4'h0;
  localparam logic [AW-1:0] OFS_SC2  = 4'h1;
  localparam logic [AW-1:0] OFS_RESH = 4'h2;
  localparam logic [AW-1:0] OFS_RESL = 4'h3;
  localparam logic [AW-1:0] OFS_CVH  = 4'h4;
  localparam logic [AW-1:0] OFS_CVL  = 4'h5;
  localparam logic [AW-1:0] OFS_CFG  = 4'h6;
  localparam logic [AW-1:0] OFS_SOPT = 4'h7;

  localparam int SC1_DONE = 7;
  localparam int SC1_IEN  = 6;
  localparam int SC1_CONT = 5;
  localparam int SC2_ACT  = 7;
  localparam int SC2_TRIG = 6;
  localparam int SC2_CMPE = 5;
  localparam int SC2_CMPG = 4;
  localparam int CFG_DIV  = 5;
  localparam int CFG_FMT  = 2;
  localparam int CFG_SRC  = 0;
  localparam int SOPT_TSS = 0;

  localparam logic [4:0] CH_LAST_EXT = 5'h17;
  localparam logic [4:0] CH_TEMP     = 5'h1A;
  localparam logic [4:0] CH_BGAP     = 5'h1B;
  localparam logic [4:0] CH_REFH0    = 5'h1C;
  localparam logic [4:0] CH_REFH1    = 5'h1D;
  localparam logic [4:0] CH_REFL     = 5'h1E;
  localparam logic [4:0] CH_OFF      = 5'h1F;

  localparam logic [4:0]    RST_CHSEL = 5'h1F;
  localparam logic [RW-1:0] RST_CV    = 12'h000;
  localparam logic [RW-1:0] SAR_MID   = 12'h800;
  localparam logic [3:0]    IDX_MSB   = 4'hB;

  localparam logic [3:0] SAMPLE_TICKS   = 4'h4;
  localparam logic [1:0] SETTLE_CYC     = 2'h3;
  localparam logic [1:0] LOCAL_DIV_LOG2 = 2'h2;

  typedef enum logic [1:0] {SARC_SRC_BUS, SARC_SRC_BUS2, SARC_SRC_LOCAL, SARC_SRC_ALT} sarc_src_e;
  typedef enum logic [1:0] {SARC_FMT_8, SARC_FMT_12, SARC_FMT_10} sarc_fmt_e;
  typedef enum logic [1:0] {SARC_IDLE, SARC_SAMPLE, SARC_CONV} sarc_state_e;

  typedef struct packed {
    logic [23:0] ext;
    logic        temp;
    logic        bgap;
    logic        refh;
    logic        refl;
    logic        off;
  } sarc_sel_s;
endpackage : sarc_pkg

//--- hdl/sarc_sync2.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sarc_sync2 #(parameter int W = 1) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sarc_sync2

//--- hdl/sarc_div.sv
// Enable-pulse divider by a power of two
`timescale 1ns/1ps
module sarc_div #(parameter int W = 2) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio,
  output logic              tick_out
);
  localparam int CW = (1 << W) - 1;
  logic [CW-1:0] cnt_q;
  wire  [CW-1:0] lim = CW'((1 << ratio) - 1);
  wire           wrap = cnt_q >= lim;

  assign tick_out = tick_in && wrap;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (tick_in) begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
    end
  end
endmodule : sarc_div

//--- hdl/sarc_core.sv
// SAR converter control: registers, clocking, triggers, sequencing and results
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Decode channel selector onto analog select lines
// - Four selectable conversion clock sources
// - Alternate clock from pin, divided by field
// - Alternate clock keeps ticking in wait
// - Trigger from counter overflow or pin
// - Hardware trigger accepted in all modes
// - Control write aborts, restarts in software trigger mode unless off
// - Results right justified, 12/10/8 bits
// - Single conversion returns to idle
// - Compare less-than or greater-equal value
// - Twelve-bit successive approximation sequence
// - Conversions continue in wait, and in stop on the local clock only
// - Done flag with matching interrupt request
// - Done set rules and its clears
// - One conversion or continuous series
// - Start by write or hardware trigger
// - Active bit tracks conversion in progress
module sarc_core (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [sarc_pkg::AW-1:0] reg_addr,
  input  wire logic [sarc_pkg::DW-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [sarc_pkg::DW-1:0] reg_rdata_q,
  input  wire logic                    external_reference_clock,
  input  wire logic                    rtc_overflow,
  input  wire logic                    irq_pin,
  input  wire logic                    cpu_stop3,
  input  wire logic                    ana_cmp_hi,
  output sarc_pkg::sarc_sel_s          ana_sel_q,
  output logic                         ana_sample_q,
  output logic                         ana_conv_q,
  output logic      [sarc_pkg::RW-1:0] ana_trial_q,
  output logic                         conv_irq_q
);
  logic [4:0]              channel_selector_q;
  logic                    ien_q;
  logic                    continuous_mode_enable_q;
  logic                    conversion_done_flag_q;
  logic                    trigger_type_select_q;
  logic                    compare_function_enable_q;
  logic                    cmp_ge_q;
  logic [1:0]              clock_divide_field_q;
  logic [1:0]              fmt_q;
  logic [1:0]              src_q;
  logic                    trigger_source_select_q;
  logic [sarc_pkg::RW-1:0] cv_q;
  logic [sarc_pkg::RW-1:0] res_q;
  logic                    conversion_active_bit_q;
  logic                    half_q;
  logic                    alt_prev_q;
  logic                    hw_prev_q;
  sarc_pkg::sarc_state_e   state_q;
  sarc_pkg::sarc_state_e   state_d;
  logic [3:0]              scnt_q;
  logic [3:0]              idx_q;
  logic [1:0]              settle_q;
  logic [3:0]              pin_s;
  logic                    local_async_conv_clock;
  logic                    conversion_clock;
  logic                    src_tick;

  localparam int CFG_DIV_HI = sarc_pkg::CFG_DIV + 1;
  localparam int CFG_FMT_HI = sarc_pkg::CFG_FMT + 1;
  localparam int CFG_SRC_HI = sarc_pkg::CFG_SRC + 1;

  // Register decode
  wire wr_sc1  = reg_wr && reg_addr == sarc_pkg::OFS_SC1;
  wire wr_sc2  = reg_wr && reg_addr == sarc_pkg::OFS_SC2;
  wire wr_cvh  = reg_wr && reg_addr == sarc_pkg::OFS_CVH;
  wire wr_cvl  = reg_wr && reg_addr == sarc_pkg::OFS_CVL;
  wire wr_cfg  = reg_wr && reg_addr == sarc_pkg::OFS_CFG;
  wire wr_sopt = reg_wr && reg_addr == sarc_pkg::OFS_SOPT;
  wire rd_resl = reg_rd && reg_addr == sarc_pkg::OFS_RESL;

  // Pins are synchronised before use; comparator shares the same stages
  sarc_sync2 #(.W(4)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({ana_cmp_hi, irq_pin, rtc_overflow, external_reference_clock}),
    .q        (pin_s)
  );
  wire alt_s = pin_s[0];
  wire cmp_s = pin_s[3];

  // Local clock is an internal divider, so it survives stop3 with the core clock
  sarc_div #(.W(2)) u_local (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick_in  (1'b1),
    .ratio    (sarc_pkg::LOCAL_DIV_LOG2),
    .tick_out (local_async_conv_clock)
  );

  wire alt_tick = alt_s && !alt_prev_q;
  // Bus-derived and alternate ticks stop in stop3; only the local clock runs there
  assign src_tick = (src_q == sarc_pkg::SARC_SRC_BUS)   ? !cpu_stop3 :
                    (src_q == sarc_pkg::SARC_SRC_BUS2)  ? half_q && !cpu_stop3 :
                    (src_q == sarc_pkg::SARC_SRC_LOCAL) ? local_async_conv_clock :
                    alt_tick && !cpu_stop3;

  sarc_div #(.W(2)) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick_in  (src_tick),
    .ratio    (clock_divide_field_q),
    .tick_out (conversion_clock)
  );

  // Hardware trigger, edge detected in every power mode
  wire hw_lvl = trigger_source_select_q ? pin_s[2] : pin_s[1];
  wire hw_evt = hw_lvl && !hw_prev_q;
  wire hw_start = trigger_type_select_q && hw_evt && state_q == sarc_pkg::SARC_IDLE
                  && channel_selector_q != sarc_pkg::CH_OFF;
  wire sw_start = wr_sc1 && !trigger_type_select_q
                  && reg_wdata[4:0] != sarc_pkg::CH_OFF;

  // Approximation step
  wire [11:0] bit_m    = 12'h001 << idx_q;
  wire [11:0] keep     = cmp_s ? ana_trial_q : (ana_trial_q & ~bit_m);
  wire [11:0] sar_next = keep | (bit_m >> 1);
  wire        eval     = state_q == sarc_pkg::SARC_CONV && settle_q == 2'h0 && conversion_clock;
  wire        complete = eval && idx_q == 4'h0 && !wr_sc1;

  wire [11:0] fmt_res = (fmt_q == sarc_pkg::SARC_FMT_8)  ? {4'h0, keep[11:4]} :
                        (fmt_q == sarc_pkg::SARC_FMT_10) ? {2'h0, keep[11:2]} :
                        keep;
  wire cmp_true = cmp_ge_q ? (fmt_res >= cv_q) : (fmt_res < cv_q);
  wire done_set = complete && (!compare_function_enable_q || cmp_true);
  wire done_clr = wr_sc1 || rd_resl;
  wire done_d   = done_set || (conversion_done_flag_q && !done_clr);

  // Reserved codes 11000/11001 select nothing but still convert
  wire [23:0] ext_dec = (channel_selector_q <= sarc_pkg::CH_LAST_EXT) ?
                        (24'h00_0001 << channel_selector_q) : 24'h00_0000;
  wire sel_refh = channel_selector_q == sarc_pkg::CH_REFH0
                  || channel_selector_q == sarc_pkg::CH_REFH1;
  wire sarc_pkg::sarc_sel_s sel_d = {ext_dec,
                                     channel_selector_q == sarc_pkg::CH_TEMP,
                                     channel_selector_q == sarc_pkg::CH_BGAP,
                                     sel_refh,
                                     channel_selector_q == sarc_pkg::CH_REFL,
                                     channel_selector_q == sarc_pkg::CH_OFF};

  always_comb begin
    state_d = state_q;
    if (wr_sc1) begin
      state_d = sw_start ? sarc_pkg::SARC_SAMPLE : sarc_pkg::SARC_IDLE;
    end else begin
      case (state_q)
        sarc_pkg::SARC_IDLE: begin
          if (hw_start) begin
            state_d = sarc_pkg::SARC_SAMPLE;
          end
        end
        sarc_pkg::SARC_SAMPLE: begin
          if (conversion_clock && scnt_q == 4'h0) begin
            state_d = sarc_pkg::SARC_CONV;
          end
        end
        sarc_pkg::SARC_CONV: begin
          if (complete) begin
            state_d = (continuous_mode_enable_q && channel_selector_q != sarc_pkg::CH_OFF)
                      ? sarc_pkg::SARC_SAMPLE : sarc_pkg::SARC_IDLE;
          end
        end
        default: state_d = sarc_pkg::SARC_IDLE;
      endcase
    end
  end

  wire enter_smp  = state_d == sarc_pkg::SARC_SAMPLE && (state_q != sarc_pkg::SARC_SAMPLE || wr_sc1);
  wire enter_conv = state_d == sarc_pkg::SARC_CONV && state_q == sarc_pkg::SARC_SAMPLE;

  wire [7:0] rd_mux =
    (reg_addr == sarc_pkg::OFS_SC1)  ? {conversion_done_flag_q, ien_q,
                                        continuous_mode_enable_q, channel_selector_q} :
    (reg_addr == sarc_pkg::OFS_SC2)  ? {conversion_active_bit_q, trigger_type_select_q,
                                        compare_function_enable_q, cmp_ge_q, 4'h0} :
    (reg_addr == sarc_pkg::OFS_RESH) ? {4'h0, res_q[11:8]} :
    (reg_addr == sarc_pkg::OFS_RESL) ? res_q[7:0] :
    (reg_addr == sarc_pkg::OFS_CVH)  ? {4'h0, cv_q[11:8]} :
    (reg_addr == sarc_pkg::OFS_CVL)  ? cv_q[7:0] :
    (reg_addr == sarc_pkg::OFS_CFG)  ? {1'b0, clock_divide_field_q, 1'b0, fmt_q, src_q} :
    (reg_addr == sarc_pkg::OFS_SOPT) ? {7'h00, trigger_source_select_q} :
    8'h00;

  // Software registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_selector_q        <= sarc_pkg::RST_CHSEL;
      ien_q                     <= 1'b0;
      continuous_mode_enable_q  <= 1'b0;
      trigger_type_select_q     <= 1'b0;
      compare_function_enable_q <= 1'b0;
      cmp_ge_q                  <= 1'b0;
      clock_divide_field_q      <= 2'h0;
      fmt_q                     <= 2'h0;
      src_q                     <= 2'h0;
      trigger_source_select_q   <= 1'b0;
      cv_q                      <= sarc_pkg::RST_CV;
    end else begin
      if (wr_sc1) begin
        ien_q                    <= reg_wdata[sarc_pkg::SC1_IEN];
        continuous_mode_enable_q <= reg_wdata[sarc_pkg::SC1_CONT];
        channel_selector_q       <= reg_wdata[4:0];
      end
      if (wr_sc2) begin
        trigger_type_select_q     <= reg_wdata[sarc_pkg::SC2_TRIG];
        compare_function_enable_q <= reg_wdata[sarc_pkg::SC2_CMPE];
        cmp_ge_q                  <= reg_wdata[sarc_pkg::SC2_CMPG];
      end
      if (wr_cvh) cv_q[11:8] <= reg_wdata[3:0];
      if (wr_cvl) cv_q[7:0] <= reg_wdata;
      if (wr_cfg) begin
        clock_divide_field_q <= reg_wdata[CFG_DIV_HI:sarc_pkg::CFG_DIV];
        fmt_q                <= reg_wdata[CFG_FMT_HI:sarc_pkg::CFG_FMT];
        src_q                <= reg_wdata[CFG_SRC_HI:sarc_pkg::CFG_SRC];
      end
      if (wr_sopt) trigger_source_select_q <= reg_wdata[sarc_pkg::SOPT_TSS];
    end
  end

  // Sequencer and status
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q                 <= sarc_pkg::SARC_IDLE;
      scnt_q                  <= 4'h0;
      idx_q                   <= 4'h0;
      settle_q                <= 2'h0;
      ana_trial_q             <= 12'h000;
      res_q                   <= 12'h000;
      conversion_done_flag_q  <= 1'b0;
      conversion_active_bit_q <= 1'b0;
      half_q                  <= 1'b0;
      alt_prev_q              <= 1'b0;
      hw_prev_q               <= 1'b0;
    end else begin
      state_q                 <= state_d;
      conversion_active_bit_q <= state_d != sarc_pkg::SARC_IDLE;
      conversion_done_flag_q  <= done_d;
      half_q                  <= !half_q;
      alt_prev_q              <= alt_s;
      hw_prev_q               <= hw_lvl;
      if (done_set) res_q <= fmt_res;
      if (enter_smp) begin
        scnt_q <= sarc_pkg::SAMPLE_TICKS - 4'h1;
      end else if (state_q == sarc_pkg::SARC_SAMPLE && conversion_clock) begin
        scnt_q <= scnt_q - 4'h1;
      end
      if (enter_conv) begin
        ana_trial_q <= sarc_pkg::SAR_MID;
        idx_q       <= sarc_pkg::IDX_MSB;
        settle_q    <= sarc_pkg::SETTLE_CYC;
      end else if (state_q == sarc_pkg::SARC_CONV && settle_q != 2'h0) begin
        settle_q <= settle_q - 2'h1;
      end else if (eval) begin
        ana_trial_q <= (idx_q == 4'h0) ? keep : sar_next;
        idx_q       <= idx_q - 4'h1;
        settle_q    <= sarc_pkg::SETTLE_CYC;
      end
    end
  end

  // Outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_sel_q    <= '0;
      ana_sample_q <= 1'b0;
      ana_conv_q   <= 1'b0;
      conv_irq_q   <= 1'b0;
      reg_rdata_q  <= 8'h00;
    end else begin
      ana_sel_q    <= sel_d;
      ana_sample_q <= state_d == sarc_pkg::SARC_SAMPLE;
      ana_conv_q   <= state_d == sarc_pkg::SARC_CONV;
      conv_irq_q   <= done_d && ien_q;
      reg_rdata_q  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence conv_end;
    complete && !wr_sc1;
  endsequence
  sequence back_idle;
    !conversion_active_bit_q ##1 !ana_conv_q;
  endsequence

  done_set_a: assert property (done_set |=> conversion_done_flag_q)
    else $error("done flag not set after completion");
  done_clr_a: assert property (done_clr && !done_set |=> !conversion_done_flag_q)
    else $error("done flag not cleared");
  cmp_block_a: assert property (complete && compare_function_enable_q && !cmp_true
    && !conversion_done_flag_q |=> !conversion_done_flag_q)
    else $error("done set on false compare");
  write_abort_a: assert property (wr_sc1 && reg_wdata[4:0] == sarc_pkg::CH_OFF
    |=> !conversion_active_bit_q)
    else $error("write to off did not abort");
  sw_start_a: assert property (sw_start |=> conversion_active_bit_q && ana_sample_q)
    else $error("software start missing");
  hw_start_a: assert property (hw_start && !wr_sc1 |=> ana_sample_q)
    else $error("hardware start missing");
  single_idle_a: assert property (conv_end and !continuous_mode_enable_q |=> back_idle)
    else $error("single conversion did not return idle");
  cont_run_a: assert property (conv_end and continuous_mode_enable_q
    and channel_selector_q != sarc_pkg::CH_OFF |=> ana_sample_q)
    else $error("continuous series stopped");
  fmt_byte_a: assert property (done_set && fmt_q == sarc_pkg::SARC_FMT_8
    |=> res_q[11:8] == 4'h0)
    else $error("8-bit result not right justified");
  chan_off_a: assert property (rst_n && channel_selector_q == sarc_pkg::CH_OFF
    |=> ana_sel_q.off && ana_sel_q.ext == 24'h00_0000)
    else $error("off code decode wrong");
  irq_follow_a: assert property (conversion_done_flag_q && ien_q && !done_clr
    |=> conv_irq_q)
    else $error("interrupt request missing");
endmodule : sarc_core

//--- verification/sarc_ana_model.sv
// Behavioural analog core: selected input level and comparator
`timescale 1ns/1ps
module sarc_ana_model (
  input  wire logic                    core_clk,
  input  wire logic [11:0]             ext_base,
  input  wire sarc_pkg::sarc_sel_s     ana_sel_q,
  input  wire logic                    ana_conv_q,
  input  wire logic [sarc_pkg::RW-1:0] ana_trial_q,
  output logic                         ana_cmp_hi
);
  logic [11:0] level;
  logic        junk_q = 1'h0;
  always_comb begin
    level = 12'h000;
    for (int i = 0; i < 24; i++) if (ana_sel_q.ext[i]) level = ext_base + (12'(i) << 4);
    if (ana_sel_q.temp) level = 12'h5A5;
    // Software has the bandgap buffer on before this channel is read
    if (ana_sel_q.bgap) level = 12'h3C3;
    if (ana_sel_q.refh) level = 12'hFFF;
  end
  // Outside approximation the comparator output is noise, never a held value
  always @(posedge core_clk) junk_q <= ~junk_q;
  assign ana_cmp_hi = ana_conv_q ? (level >= ana_trial_q) : junk_q;
endmodule : sarc_ana_model

//--- verification/sarc_core_bench.sv
// Self-checking bench for the SAR converter control logic
`timescale 1ns/1ps
module sarc_core_bench;
  logic                    core_clk = 1'h0;
  logic                    rst_n = 1'h0;
  logic [sarc_pkg::AW-1:0] reg_addr = 4'h0;
  logic [sarc_pkg::DW-1:0] reg_wdata = 8'h00;
  logic                    reg_wr = 1'h0;
  logic                    reg_rd = 1'h0;
  logic [sarc_pkg::DW-1:0] reg_rdata_q;
  logic                    external_reference_clock = 1'h0;
  logic                    rtc_overflow = 1'h0;
  logic                    irq_pin = 1'h0;
  logic                    cpu_stop3 = 1'h0;
  logic                    ana_cmp_hi;
  sarc_pkg::sarc_sel_s     ana_sel_q;
  logic                    ana_sample_q;
  logic                    ana_conv_q;
  logic [sarc_pkg::RW-1:0] ana_trial_q;
  logic                    conv_irq_q;
  int                      errors = 0;
  int                      samples_checked = 0;
  logic [7:0]              d;
  logic [7:0]              h;
  logic [7:0]              l;
  int                      k;
  // Row: selector, format, expected result
  localparam logic [18:0] ROWS [8] = '{{5'h00, 2'h1, 12'h123}, {5'h17, 2'h1, 12'h293},
    {5'h1B, 2'h1, 12'h3C3}, {5'h1A, 2'h2, 12'h169}, {5'h1C, 2'h0, 12'h0FF},
    {5'h1D, 2'h3, 12'hFFF}, {5'h1E, 2'h1, 12'h000}, {5'h05, 2'h0, 12'h017}};
  // Row: configuration, sample ticks in core cycles
  localparam logic [7:0] CLKS [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h64, 8'h24};
  localparam int         TK   [6] = '{1, 2, 4, 2, 8, 2};

  sarc_core i_sarc_core (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .external_reference_clock(external_reference_clock), .rtc_overflow(rtc_overflow),
    .irq_pin(irq_pin), .cpu_stop3(cpu_stop3), .ana_cmp_hi(ana_cmp_hi),
    .ana_sel_q(ana_sel_q), .ana_sample_q(ana_sample_q), .ana_conv_q(ana_conv_q),
    .ana_trial_q(ana_trial_q), .conv_irq_q(conv_irq_q));
  sarc_ana_model i_sarc_ana_model (.core_clk(core_clk), .ext_base(12'h123),
    .ana_sel_q(ana_sel_q), .ana_conv_q(ana_conv_q), .ana_trial_q(ana_trial_q),
    .ana_cmp_hi(ana_cmp_hi));

  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Alternate clock at half the core rate
  always @(posedge core_clk) external_reference_clock <= ~external_reference_clock;

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    // Read data stands for one cycle only; take it mid-cycle where it is settled
    @(negedge core_clk);
    v = reg_rdata_q;
    @(posedge core_clk);
  endtask : rd

  // Polls one status bit; a lost conversion would otherwise hang the run
  task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      rd(a, d);
      if (d[b] === v) return;
    end
    errors++;
    $display("MISMATCH %0t status bit never reached", $time);
    give_verdict();
  endtask : wait_bit

  task automatic result(input logic [15:0] exp);
    rd(sarc_pkg::OFS_RESH, h);
    rd(sarc_pkg::OFS_RESL, l);
    chk({h, l}, exp);
  endtask : result

  task automatic pulse(input logic pin);
    if (pin) irq_pin <= 1'h1;
    else rtc_overflow <= 1'h1;
    repeat (4) @(posedge core_clk);
    irq_pin      <= 1'h0;
    rtc_overflow <= 1'h0;
    repeat (4) @(posedge core_clk);
  endtask : pulse

  function automatic logic [31:0] sel_of(input logic [4:0] c);
    if (c <= 5'h17) return 32'h0000_0020 << c;
    if (c == 5'h1A) return 32'h0000_0010;
    if (c == 5'h1B) return 32'h0000_0008;
    if (c == 5'h1E) return 32'h0000_0002;
    if (c == 5'h1F) return 32'h0000_0001;
    return (c >= 5'h1C) ? 32'h0000_0004 : 32'h0000_0000;
  endfunction : sel_of

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(sarc_pkg::OFS_SC1, d);
    chk(d, 8'h1F);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d, 8'h00);
    rd(4'hF, d);
    chk(d, 8'h00);
    chk(ana_sel_q, sel_of(5'h1F));
    wr(sarc_pkg::OFS_SC1, 8'h1F);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d[7], 1'h0);
    // Bandgap row precedes temperature row
    foreach (ROWS[r]) begin
      wr(sarc_pkg::OFS_CFG, {4'h0, ROWS[r][13:12], 2'h0});
      wr(sarc_pkg::OFS_SC1, {3'h0, ROWS[r][18:14]});
      wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
      rd(sarc_pkg::OFS_SC1, d);
      chk(d[7], 1'h1);
      chk(conv_irq_q, 1'h0);
      chk(ana_sel_q, sel_of(ROWS[r][18:14]));
      result({4'h0, ROWS[r][11:0]});
      rd(sarc_pkg::OFS_SC1, d);
      chk(d[7], 1'h0);
    end
    // Sample phase spans four conversion ticks of the chosen source
    foreach (CLKS[c]) begin
      wr(sarc_pkg::OFS_CFG, CLKS[c]);
      reg_addr  <= sarc_pkg::OFS_SC1;
      reg_wdata <= 8'h00;
      reg_wr    <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      k = 0;
      for (int i = 0; i < 300; i++) begin
        @(posedge core_clk);
        if (ana_sample_q === 1'h1) k++;
        else if (k > 0) break;
      end
      chk(k >= 3 * TK[c] && k <= 4 * TK[c] + 1, 1'h1);
      wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
      result(16'h0123);
    end
    wr(sarc_pkg::OFS_CFG, 8'h04);
    wr(sarc_pkg::OFS_SC1, 8'h18);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    chk(ana_sel_q, 32'h0000_0000);
    wr(sarc_pkg::OFS_SC1, 8'h00);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    wr(sarc_pkg::OFS_SC1, 8'h17);
    rd(sarc_pkg::OFS_SC1, d);
    chk(d[7], 1'h0);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d[7], 1'h1);
    wr(sarc_pkg::OFS_SC1, 8'h00);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    result(16'h0123);
    wr(sarc_pkg::OFS_SC1, 8'h20);
    wait_bit(sarc_pkg::OFS_SC1, 7, 1'h1);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d[7], 1'h1);
    rd(sarc_pkg::OFS_RESL, d);
    wait_bit(sarc_pkg::OFS_SC1, 7, 1'h1);
    wr(sarc_pkg::OFS_SC1, 8'h1F);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d[7], 1'h0);
    wr(sarc_pkg::OFS_CVH, 8'h02);
    wr(sarc_pkg::OFS_CVL, 8'h00);
    wr(sarc_pkg::OFS_SC2, 8'h30);
    wr(sarc_pkg::OFS_SC1, 8'h00);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    rd(sarc_pkg::OFS_SC1, d);
    chk(d[7], 1'h0);
    wr(sarc_pkg::OFS_SC2, 8'h20);
    wr(sarc_pkg::OFS_SC1, 8'h40);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    rd(sarc_pkg::OFS_SC1, d);
    chk(d[7], 1'h1);
    chk(conv_irq_q, 1'h1);
    rd(sarc_pkg::OFS_RESL, d);
    @(posedge core_clk);
    chk(conv_irq_q, 1'h0);
    wr(sarc_pkg::OFS_SC2, 8'h40);
    wr(sarc_pkg::OFS_SOPT, 8'h00);
    wr(sarc_pkg::OFS_SC1, 8'h00);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d, 8'h40);
    pulse(1'h1);
    rd(sarc_pkg::OFS_SC2, d);
    chk(d, 8'h40);
    pulse(1'h0);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    rd(sarc_pkg::OFS_SC1, d);
    chk(d[7], 1'h1);
    result(16'h0123);
    // Local clock in stop, since the alternate one is gone there
    wr(sarc_pkg::OFS_CFG, 8'h06);
    wr(sarc_pkg::OFS_SOPT, 8'h01);
    cpu_stop3 <= 1'h1;
    pulse(1'h1);
    wait_bit(sarc_pkg::OFS_SC2, 7, 1'h0);
    rd(sarc_pkg::OFS_SC1, d);
    chk(d[7], 1'h1);
    result(16'h0123);
    cpu_stop3 <= 1'h0;
    // Reset while idle (SC1 write starts nothing in hardware trigger mode) must bring SC1, SC2 and the select lines back to their idle values
    wr(sarc_pkg::OFS_SC1, 8'h20);
    rst_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(sarc_pkg::OFS_SC2, d);
    chk(d, 8'h00);
    rd(sarc_pkg::OFS_SC1, d);
    chk(d, 8'h1F);
    chk(ana_sel_q, sel_of(5'h1F));
    give_verdict();
  end
endmodule : sarc_core_bench
